// file: rtl/spg_regs.sv
// sync phase error status and full-scale gain register slice
// assumes a byte register port driven by the serial port back end, and an
// alignment engine outside that reports measurements, adjustments and sysref
//
// Summary of operation
// - sysref pulse sets sticky seen flag
// - current error, 4-bit signed, bits 3:0
// - adjustment copies error to previous, zeroes current
// - below-window flag in bit 7
// - above-window flag in bit 6
// - channel 0 gain split 2+8 bits
// - channel 1 gain split the same
// - channel 2 gain msbs, upper bits reserved
// - gain code maps to full-scale current
// - sticky clear rising edge clears both flags, except one set in the same cycle
`timescale 1ns/1ps
module spg_regs (
  // clock and reset
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst_n,
  // register port
  input  wire spg_pkg::spg_req_t                     reg_req,
  output logic      [spg_pkg::DATA_W-1:0]            reg_rdata,
  output logic                                       reg_rd_valid,
  // alignment engine
  input  wire spg_pkg::spg_align_t                   align,
  input  wire logic                                  sticky_clear_trigger,
  // status to the rest of the sync block
  output logic                                       sysref_seen_flag,
  output logic                                       rotated_flag,
  output logic      [spg_pkg::ERR_W-1:0]             phase_error_prev,
  // gain codes to the analog full-scale current stage
  output logic      [spg_pkg::GAIN_W-1:0]            fullscale_gain_ch0,
  output logic      [spg_pkg::GAIN_W-1:0]            fullscale_gain_ch1,
  output logic      [spg_pkg::GAIN_HI_W-1:0]         fullscale_gain_ch2
);
  import spg_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [ERR_W-1:0]  phase_error_now;
    logic [ERR_W-1:0]  prev;
    logic              below;
    logic              above;
    logic              seen;
    logic              rotated;
    logic              clr_q;
    logic              rd_valid;
    logic [DATA_W-1:0] rd_stat;
  } spg_state_t;

  spg_state_t st;
  spg_state_t next_st;

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  logic                           gain_wr_hi;
  logic                           gain_wr_lo;
  logic                           gain_rd_hi;
  logic [1:0]                     gain_ch;
  logic                           gain_hit;
  logic [NUM_CH-1:0][GAIN_W-1:0]  gain_word;

  always_comb begin
    gain_hit   = 1'b1;
    gain_rd_hi = 1'b0;
    gain_ch    = 2'h0;
    case (reg_req.addr)
      GAIN_CH0_HIGH_OFS: begin
        gain_rd_hi = 1'b1;
      end
      GAIN_CH0_LOW_OFS: begin
        gain_ch = 2'h0;
      end
      GAIN_CH1_HIGH_OFS: begin
        gain_rd_hi = 1'b1;
        gain_ch    = 2'h1;
      end
      GAIN_CH1_LOW_OFS: begin
        gain_ch = 2'h1;
      end
      GAIN_CH2_HIGH_OFS: begin
        gain_rd_hi = 1'b1;
        gain_ch    = 2'h2;
      end
      default: begin
        gain_hit = 1'b0;
      end
    endcase
    gain_wr_hi = reg_req.wr_en && gain_hit && gain_rd_hi;
    gain_wr_lo = reg_req.wr_en && gain_hit && !gain_rd_hi;
  end

  spg_gain_regs #(
    .NUM_CH (NUM_CH)
  ) u_gain (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_hi   (gain_wr_hi),
    .wr_lo   (gain_wr_lo),
    .wr_ch   (gain_ch),
    .wr_data (reg_req.wdata),
    .rd_hi   (gain_rd_hi),
    .rd_ch   (gain_ch),
    // gain reads are served below from the stored words, so that reg_rdata
    // stays a single flop instead of a mux of two stores
    .rd_data (),
    .gain    (gain_word)
  );

  // --------------------------------------------------------------------------
  // window comparison on the signed error
  // --------------------------------------------------------------------------
  logic signed [ERR_W:0] err_s;
  logic signed [ERR_W:0] lim_s;
  logic                  err_below;
  logic                  err_above;

  always_comb begin
    // registered error: the flags trail a new error by one cycle, which keeps
    // this compare out of the next-state loop
    err_s     = {st.phase_error_now[ERR_W-1], st.phase_error_now};
    lim_s     = {1'b0, align.win_limit};
    err_below = err_s < -lim_s;
    err_above = err_s > lim_s;
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  logic clr_rise;

  always_comb begin
    clr_rise = sticky_clear_trigger && !st.clr_q;
    next_st  = st;
    next_st.clr_q = sticky_clear_trigger;

    // the adjustment has priority: a measurement in the same cycle is the one
    // that got corrected, so it goes to the previous field
    if (align.adjust) begin
      next_st.prev            = align.error;
      next_st.phase_error_now = ERR_RST;
    end else if (align.valid) begin
      next_st.phase_error_now = align.error;
    end

    // sets win over a clear in the same cycle so no event is lost
    if (clr_rise) begin
      next_st.seen    = 1'b0;
      next_st.rotated = 1'b0;
    end
    if (align.sysref) begin
      next_st.seen = 1'b1;
    end
    if (align.adjust) begin
      next_st.rotated = 1'b1;
    end

    next_st.below = err_below;
    next_st.above = err_above;

    // status reads are served here; writes to them fall through
    next_st.rd_valid = reg_req.rd_en;
    next_st.rd_stat  = DATA_RST;
    if (reg_req.rd_en) begin
      case (reg_req.addr)
        SYNC_PHASE_ERROR_LOW_OFS: begin
          next_st.rd_stat = {{(DATA_W-ERR_W){1'b0}}, st.phase_error_now};
        end
        SYNC_PHASE_ERROR_HIGH_OFS: begin
          next_st.rd_stat[BELOW_BIT] = st.below;
          next_st.rd_stat[ABOVE_BIT] = st.above;
        end
        default: begin
          if (gain_hit && gain_rd_hi) begin
            // upper six bits reserved, read as zero
            next_st.rd_stat = {{(DATA_W-GAIN_HI_W){1'b0}},
                               gain_word[gain_ch][GAIN_W-1 -: GAIN_HI_W]};
          end else if (gain_hit) begin
            next_st.rd_stat = gain_word[gain_ch][GAIN_LO_W-1:0];
          end else begin
            next_st.rd_stat = DATA_RST;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign reg_rdata          = st.rd_stat;
  assign reg_rd_valid       = st.rd_valid;
  assign sysref_seen_flag   = st.seen;
  assign rotated_flag       = st.rotated;
  assign phase_error_prev   = st.prev;
  // raw codes: the current stage spans FS_MIN_UA..FS_MAX_UA with
  // FS_MID_UA at code zero
  assign fullscale_gain_ch0 = gain_word[0];
  assign fullscale_gain_ch1 = gain_word[1];
  assign fullscale_gain_ch2 = gain_word[2][GAIN_W-1 -: GAIN_HI_W];

endmodule

// file: rtl/spg_pkg.sv
// shared constants and carriers for the sync phase error and gain register slice
// assumes a byte-wide register port in the device clock domain
package spg_pkg;

  // --------------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // --------------------------------------------------------------------------
  // offsets
  // --------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SYNC_PHASE_ERROR_LOW_OFS  = 12'h03C;
  localparam logic [ADDR_W-1:0] SYNC_PHASE_ERROR_HIGH_OFS = 12'h03D;
  localparam logic [ADDR_W-1:0] GAIN_CH0_HIGH_OFS         = 12'h040;
  localparam logic [ADDR_W-1:0] GAIN_CH0_LOW_OFS          = 12'h041;
  localparam logic [ADDR_W-1:0] GAIN_CH1_HIGH_OFS         = 12'h042;
  localparam logic [ADDR_W-1:0] GAIN_CH1_LOW_OFS          = 12'h043;
  localparam logic [ADDR_W-1:0] GAIN_CH2_HIGH_OFS         = 12'h044;

  // --------------------------------------------------------------------------
  // fields
  // --------------------------------------------------------------------------
  localparam int ERR_W        = 4;   // phase_error_now_field in bits 3:0
  localparam int BELOW_BIT    = 7;
  localparam int ABOVE_BIT    = 6;
  localparam int GAIN_W       = 10;
  localparam int GAIN_HI_W    = 2;   // gain msbs in bits 1:0 of the high register
  localparam int GAIN_LO_W    = 8;
  localparam int NUM_CH       = 3;
  localparam int NUM_CH_LOW   = 2;   // channels whose low byte lives in this slice

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [ERR_W-1:0]  ERR_RST  = 4'h0;
  localparam logic [GAIN_W-1:0] GAIN_RST = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // --------------------------------------------------------------------------
  // analog full-scale current per code, in microamps (used by the analog side)
  // --------------------------------------------------------------------------
  localparam int FS_MAX_UA = 27000;
  localparam int FS_MID_UA = 20480;
  localparam int FS_MIN_UA = 13900;

  // --------------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic              wr_en;
    logic              rd_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } spg_req_t;

  typedef struct packed {
    logic              valid;      // a new measurement is on error
    logic              adjust;     // the clocks were adjusted on this sysref
    logic              sysref;     // sysref pulse received
    logic [ERR_W-1:0]  error;      // signed cycles between lmfc and sysref edges
    logic [ERR_W-1:0]  win_limit;  // unsigned window half width
  } spg_align_t;

endpackage

// file: rtl/spg_gain_regs.sv
// storage for the per-channel full-scale gain words
// assumes the caller decodes addresses; read data come out one cycle later
`timescale 1ns/1ps
module spg_gain_regs #(
  parameter int NUM_CH = spg_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst_n,
  // write port
  input  wire logic                              wr_hi,
  input  wire logic                              wr_lo,
  input  wire logic [1:0]                        wr_ch,
  input  wire logic [spg_pkg::DATA_W-1:0]        wr_data,
  // read port
  input  wire logic                              rd_hi,
  input  wire logic [1:0]                        rd_ch,
  output logic      [spg_pkg::DATA_W-1:0]        rd_data,
  // gain words
  output logic      [NUM_CH-1:0][spg_pkg::GAIN_W-1:0] gain
);
  import spg_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0][GAIN_W-1:0] word;
    logic [DATA_W-1:0]             rd;
  } spg_gain_state_t;

  spg_gain_state_t st;
  spg_gain_state_t next_st;

  always_comb begin
    next_st = st;
    for (int c = 0; c < NUM_CH; c++) begin
      // writing one half leaves the other half and all else untouched
      if (wr_hi && wr_ch == c[1:0]) begin
        next_st.word[c][GAIN_W-1 -: GAIN_HI_W] = wr_data[GAIN_HI_W-1:0];
      end
      if (wr_lo && wr_ch == c[1:0]) begin
        next_st.word[c][GAIN_LO_W-1:0] = wr_data;
      end
    end
    next_st.rd = DATA_RST;
    if (rd_ch < NUM_CH[1:0]) begin
      if (rd_hi) begin
        // upper six bits always zero
        next_st.rd = {{(DATA_W-GAIN_HI_W){1'b0}},
                      st.word[rd_ch][GAIN_W-1 -: GAIN_HI_W]};
      end else begin
        next_st.rd = st.word[rd_ch][GAIN_LO_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd;
  assign gain    = st.word;

endmodule

// file: verification/spg_regs_properties.sv
// concurrent checks on the sync phase error and gain register slice
// assumes it is bound to spg_regs and sees one clock domain
`timescale 1ns/1ps
module spg_regs_properties (
  // clock and reset
  input wire logic                           sys_clk,
  input wire logic                           rst_n,
  // register port
  input wire spg_pkg::spg_req_t              reg_req,
  input wire logic [spg_pkg::DATA_W-1:0]     reg_rdata,
  input wire logic                           reg_rd_valid,
  // alignment engine and status
  input wire spg_pkg::spg_align_t            align,
  input wire logic                           sticky_clear_trigger,
  input wire logic                           sysref_seen_flag,
  input wire logic                           rotated_flag,
  input wire logic [spg_pkg::ERR_W-1:0]      phase_error_prev,
  // gain codes
  input wire logic [spg_pkg::GAIN_W-1:0]     fullscale_gain_ch0,
  input wire logic [spg_pkg::GAIN_W-1:0]     fullscale_gain_ch1,
  input wire logic [spg_pkg::GAIN_HI_W-1:0]  fullscale_gain_ch2
);
  import spg_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_seen_set;
    align.sysref |=> sysref_seen_flag;
  endproperty
  a_seen_set: assert property (p_seen_set) else $error("seen flag not set");
  property p_seen_hold;
    sysref_seen_flag && !$rose(sticky_clear_trigger) |=> sysref_seen_flag;
  endproperty
  a_seen_hold: assert property (p_seen_hold) else $error("seen flag lost");
  property p_clear;
    $rose(sticky_clear_trigger) && !align.sysref && !align.adjust
      |=> !sysref_seen_flag && !rotated_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("sticky flags not cleared");
  property p_prev;
    align.adjust |=> rotated_flag && phase_error_prev == $past(align.error);
  endproperty
  a_prev: assert property (p_prev) else $error("previous error not captured");
  property p_rd_lat;
    reg_req.rd_en |=> reg_rd_valid ##1 !reg_rd_valid || $past(reg_req.rd_en);
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer timing wrong");
  property p_rd_idle;
    !reg_rd_valid |-> reg_rdata == DATA_RST;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle zero");
  property p_rsv;
    reg_req.rd_en && reg_req.addr == SYNC_PHASE_ERROR_LOW_OFS |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_gain_lo;
    reg_req.wr_en && reg_req.addr == GAIN_CH0_LOW_OFS
      |=> fullscale_gain_ch0[7:0] == $past(reg_req.wdata);
  endproperty
  a_gain_lo: assert property (p_gain_lo) else $error("gain low byte not stored");
  property p_gain_keep;
    !reg_req.wr_en |=> $stable(fullscale_gain_ch0) && $stable(fullscale_gain_ch1)
      && $stable(fullscale_gain_ch2);
  endproperty
  a_gain_keep: assert property (p_gain_keep) else $error("gain changed without write");
endmodule
bind spg_regs spg_regs_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .align(align),
  .sticky_clear_trigger(sticky_clear_trigger), .sysref_seen_flag(sysref_seen_flag),
  .rotated_flag(rotated_flag), .phase_error_prev(phase_error_prev),
  .fullscale_gain_ch0(fullscale_gain_ch0), .fullscale_gain_ch1(fullscale_gain_ch1),
  .fullscale_gain_ch2(fullscale_gain_ch2));

// file: verification/test_spg_regs.sv
// self-checking bench for the sync phase error and gain register slice
// assumes the bench alone drives the register port and the alignment inputs
`timescale 1ns/1ps
module test_spg_regs;
  import spg_pkg::*;
  logic                 sys_clk;
  logic                 rst_n;
  logic                 sticky_clear_trigger;
  logic                 reg_rd_valid;
  logic                 sysref_seen_flag;
  logic                 rotated_flag;
  spg_req_t             reg_req;
  spg_align_t           align;
  logic [DATA_W-1:0]    reg_rdata;
  logic [ERR_W-1:0]     phase_error_prev;
  logic [GAIN_W-1:0]    fullscale_gain_ch0;
  logic [GAIN_W-1:0]    fullscale_gain_ch1;
  logic [GAIN_HI_W-1:0] fullscale_gain_ch2;
  int                   fail_count;
  int                   tests_run;
  int                   cycles;
  spg_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .align(align),
    .sticky_clear_trigger(sticky_clear_trigger), .sysref_seen_flag(sysref_seen_flag),
    .rotated_flag(rotated_flag), .phase_error_prev(phase_error_prev),
    .fullscale_gain_ch0(fullscale_gain_ch0), .fullscale_gain_ch1(fullscale_gain_ch1),
    .fullscale_gain_ch2(fullscale_gain_ch2));
  // --------------------------------------------------------------------------
  // bus and event helpers
  // --------------------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk) #1 reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk) #1 reg_req = '0;
  endtask
  // valid and data are checked together, one cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk) #1 reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk) #1 reg_req = '0;
    chk($sformatf("read %h", a), {8'h01, exp}, {7'h00, reg_rd_valid, reg_rdata});
  endtask
  task automatic ev(input logic v, input logic j, input logic s, input logic [3:0] e);
    @(posedge sys_clk) #1 {align.valid, align.adjust, align.sysref, align.error} = {v, j, s, e};
    @(posedge sys_clk) #1 {align.valid, align.adjust, align.sysref} = 3'b000;
  endtask
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    for (int a = 16'h003C; a <= 16'h0046; a++) rd(a[ADDR_W-1:0], DATA_RST);
    chk("gain0 reset", 16'h0000, {6'h00, fullscale_gain_ch0});
    chk("gain1 reset", 16'h0000, {6'h00, fullscale_gain_ch1});
    chk("gain2 reset", 16'h0000, {14'h0000, fullscale_gain_ch2});
  endtask
  task automatic t_gain();
    wr(GAIN_CH0_HIGH_OFS, 8'hFF);
    wr(GAIN_CH0_LOW_OFS, 8'hA5);
    chk("gain0", 16'h03A5, {6'h00, fullscale_gain_ch0});
    rd(GAIN_CH0_HIGH_OFS, 8'h03);
    rd(GAIN_CH0_LOW_OFS, 8'hA5);
    wr(GAIN_CH1_HIGH_OFS, 8'h01);
    wr(GAIN_CH1_LOW_OFS, 8'hFF);
    chk("gain1 max", 16'h01FF, {6'h00, fullscale_gain_ch1});
    wr(GAIN_CH1_HIGH_OFS, 8'h02);
    wr(GAIN_CH1_LOW_OFS, 8'h00);
    chk("gain1 min", 16'h0200, {6'h00, fullscale_gain_ch1});
    rd(GAIN_CH1_HIGH_OFS, 8'h02);
    wr(GAIN_CH2_HIGH_OFS, 8'hFE);
    chk("gain2", 16'h0002, {14'h0000, fullscale_gain_ch2});
    rd(GAIN_CH2_HIGH_OFS, 8'h02);
    wr(SYNC_PHASE_ERROR_LOW_OFS, 8'hFF);
    wr(SYNC_PHASE_ERROR_HIGH_OFS, 8'hFF);
    wr(12'h045, 8'hFF);
    rd(SYNC_PHASE_ERROR_LOW_OFS, 8'h00);
    rd(SYNC_PHASE_ERROR_HIGH_OFS, 8'h00);
    rd(12'h045, 8'h00);
    chk("gain0 kept", 16'h03A5, {6'h00, fullscale_gain_ch0});
  endtask
  task automatic t_err();
    align.win_limit = 4'h2;
    ev(1'b1, 1'b0, 1'b0, 4'hD);
    rd(SYNC_PHASE_ERROR_LOW_OFS, 8'h0D);
    rd(SYNC_PHASE_ERROR_HIGH_OFS, 8'h80);
    ev(1'b1, 1'b0, 1'b0, 4'h3);
    rd(SYNC_PHASE_ERROR_LOW_OFS, 8'h03);
    rd(SYNC_PHASE_ERROR_HIGH_OFS, 8'h40);
    ev(1'b1, 1'b0, 1'b0, 4'hE);
    rd(SYNC_PHASE_ERROR_LOW_OFS, 8'h0E);
    rd(SYNC_PHASE_ERROR_HIGH_OFS, 8'h00);
    ev(1'b1, 1'b1, 1'b0, 4'h5);
    chk("prev", 16'h0015, {11'h000, rotated_flag, phase_error_prev});
    rd(SYNC_PHASE_ERROR_LOW_OFS, 8'h00);
  endtask
  // a held-high clear must not keep clearing: only its edge counts
  task automatic t_sticky();
    ev(1'b0, 1'b0, 1'b1, 4'h0);
    repeat (3) @(posedge sys_clk);
    #1 chk("seen", 16'h0003, {14'h0000, rotated_flag, sysref_seen_flag});
    @(posedge sys_clk) #1 sticky_clear_trigger = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("cleared", 16'h0000, {14'h0000, rotated_flag, sysref_seen_flag});
    ev(1'b0, 1'b0, 1'b1, 4'h0);
    chk("set again", 16'h0001, {14'h0000, rotated_flag, sysref_seen_flag});
    sticky_clear_trigger = 1'b0;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    {rst_n, sticky_clear_trigger, reg_req, align} = '0;
    {fail_count, tests_run, cycles} = '0;
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_gain();
    t_err();
    t_sticky();
    test_done();
  end
endmodule
